/* File: hdl/stsp_handset.sv */
// Handset end of the speech test port with its uplink sample FIFO
`timescale 1ns/10ps

module stsp_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 32
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic [W-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Room left
  output logic [W-1:0] out_data, // Registered read data
  output logic out_valid, // Read data present
  input wire logic out_ready // Consumer takes word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } stsp_fifo_t;
  stsp_fifo_t s_r, s_nxt;
  logic [W-1:0] mem [DEPTH];
  logic wr, rd;

  assign in_ready = (s_r.cnt < (AW+1)'(DEPTH));
  assign wr = in_valid && in_ready;
  assign rd = (s_r.cnt != '0) && (!s_r.ov || out_ready);
  assign out_data = s_r.od;
  assign out_valid = s_r.ov;

  always_comb begin
    s_nxt = s_r;
    if (out_ready) begin
      s_nxt.ov = 1'b0;
    end
    if (wr) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (rd) begin
      s_nxt.od = mem[s_r.rp];
      s_nxt.ov = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
    if (wr) begin
      mem[s_r.wp] <= in_data;
    end
  end
endmodule

// Summary of operation
// - 13-bit samples, 8000/s, 104 kbit/s lines
// - Handset alone makes bursts of bit clock
// - Simulator drives control and reset lines
// - Reset low holds transcoders and converters
// - Two's complement, MSB first, LSB last
// - Capture on rising, change on falling
// - Clock idles high, burst starts falling
// - Control lines decode to four modes
// - Lines or command select mode, declared
// - Simulator waits over 1 s before reset
// - After release, bursts as samples needed
// - Uplink first fall requests first bit
// - Downlink first fall presents first bit
// - Reset end restarts transcoders in tests
module stsp_handset
  import stsp_pkg::*;
#(
  parameter int SAMPLE_CYC_P = stsp_pkg::SAMPLE_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  stsp_if.handset_mp port, // Test port pins
  input wire logic sel_by_command, // Mode taken from command, not lines
  input wire stsp_pkg::stsp_mode_t cmd_mode, // Mode set by air command
  input wire logic [stsp_pkg::SAMPLE_W-1:0] dn_sample, // Decoded sample to send
  input wire logic dn_valid, // Decoded sample present
  output logic dn_ready, // Decoded sample taken
  output logic [stsp_pkg::SAMPLE_W-1:0] ul_sample, // Received sample to encode
  output logic ul_valid, // Received sample present
  input wire logic ul_ready, // Encoder takes sample
  output stsp_pkg::stsp_mode_t test_mode, // Active mode
  output logic xcdr_hold, // Transcoders held in reset
  output logic xcdr_restart // Transcoder restart pulse
);
  import stsp_pkg::*;

  typedef struct packed {
    logic [SYNC_LEN-1:0] rs;
    logic [SYNC_LEN-1:0] c1s;
    logic [SYNC_LEN-1:0] c2s;
    logic [SYNC_LEN-1:0] ds;
    logic rst_f;
    logic c1_f;
    logic c2_f;
    logic d_f;
    stsp_phase_t ph;
    logic [9:0] tmr;
    logic [13:0] frm;
    logic [3:0] bitn;
    logic rx_en;
    logic tx_en;
    logic [SAMPLE_W-1:0] txw;
    logic [SAMPLE_W-1:0] rxw;
    logic clk_o;
    logic dat_o;
    logic dn_ready;
    logic push;
    logic hold;
    logic restart;
    stsp_mode_t mode;
  } stsp_hs_t;

  localparam logic [9:0] HALF_LAST = 10'(HALF_BIT_CYC - 1);
  localparam logic [13:0] FRM_LAST = 14'(SAMPLE_CYC_P - 1);

  stsp_hs_t s_r, s_nxt;
  logic fifo_ready;
  logic need_rx, have_tx, tick;
  stsp_mode_t sel;

  function automatic logic [SYNC_LEN:0] sync3(logic [SYNC_LEN-1:0] sh, logic f, logic pin);
    logic [SYNC_LEN-1:0] n;
    n = {sh[SYNC_LEN-2:0], pin};
    return {n, (sh[1] == sh[2]) ? sh[2] : f};
  endfunction

  assign sel = stsp_mode_t'({s_r.c1_f, s_r.c2_f});
  assign tick = (s_r.frm == FRM_LAST);
  assign need_rx = (s_r.mode == STSP_UPLINK || s_r.mode == STSP_ACOUSTIC) && fifo_ready;
  assign have_tx = (s_r.mode == STSP_DOWNLINK || s_r.mode == STSP_ACOUSTIC) && dn_valid;

  always_comb begin
    s_nxt = s_r;
    {s_nxt.rs, s_nxt.rst_f} = sync3(s_r.rs, s_r.rst_f, port.test_rst_n);
    {s_nxt.c1s, s_nxt.c1_f} = sync3(s_r.c1s, s_r.c1_f, port.ctl1);
    {s_nxt.c2s, s_nxt.c2_f} = sync3(s_r.c2s, s_r.c2_f, port.ctl2);
    {s_nxt.ds, s_nxt.d_f} = sync3(s_r.ds, s_r.d_f, port.sim_data);
    s_nxt.dn_ready = 1'b0;
    s_nxt.push = 1'b0;
    s_nxt.restart = 1'b0;
    // one selection method at a time
    s_nxt.mode = sel_by_command ? cmd_mode : sel;
    s_nxt.hold = !s_r.rst_f;
    s_nxt.tmr = s_r.tmr + 10'h0001;
    s_nxt.frm = tick ? 14'h0000 : s_r.frm + 14'h0001;
    if (!s_r.rst_f) begin
      // counters restart at release; first frame tick right away
      s_nxt.ph = PH_IDLE;
      s_nxt.bitn = 4'h0000;
      s_nxt.frm = FRM_LAST;
      s_nxt.clk_o = 1'b1;
      s_nxt.dat_o = 1'b1;
      // restart on release in a test mode
      if (s_nxt.rst_f && s_r.mode != STSP_NORMAL) begin
        s_nxt.restart = 1'b1;
      end
    end else begin
      case (s_r.ph)
        PH_IDLE: begin
          // clock only when a word is wanted or ready
          if (tick && (need_rx || have_tx)) begin
            s_nxt.rx_en = need_rx;
            s_nxt.tx_en = have_tx;
            s_nxt.txw = have_tx ? dn_sample : SAMPLE_RST;
            s_nxt.dn_ready = have_tx;
            // burst opens with a falling edge; first bit out here
            s_nxt.clk_o = 1'b0;
            s_nxt.dat_o = have_tx ? dn_sample[SAMPLE_W-1] : 1'b1;
            s_nxt.bitn = 4'h0000;
            s_nxt.tmr = 10'h0000;
            s_nxt.ph = PH_LOW;
          end
        end
        PH_LOW: begin
          if (s_r.tmr == HALF_LAST) begin
            s_nxt.clk_o = 1'b1;
            s_nxt.rxw = {s_r.rxw[SAMPLE_W-2:0], s_r.d_f};
            s_nxt.tmr = 10'h0000;
            s_nxt.ph = PH_HIGH;
          end
        end
        PH_HIGH: begin
          if (s_r.tmr == HALF_LAST) begin
            s_nxt.tmr = 10'h0000;
            if (s_r.bitn == LAST_BIT) begin
              s_nxt.push = s_r.rx_en;
              s_nxt.bitn = 4'h0000;
              s_nxt.dat_o = 1'b1;
              s_nxt.ph = PH_IDLE;
            end else begin
              // MSB first; data changes on falling edge
              s_nxt.clk_o = 1'b0;
              s_nxt.txw = {s_r.txw[SAMPLE_W-2:0], 1'b0};
              s_nxt.dat_o = s_r.tx_en ? s_r.txw[SAMPLE_W-2] : 1'b1;
              s_nxt.bitn = s_r.bitn + 4'h0001;
              s_nxt.ph = PH_LOW;
            end
          end
        end
        default: begin
          s_nxt.ph = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.rs <= '1;
      s_r.rst_f <= 1'b1;
      s_r.clk_o <= 1'b1;
      s_r.dat_o <= 1'b1;
      s_r.hold <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // uplink words buffered toward the encoder
  stsp_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(s_r.rxw),
    .in_valid(s_r.push),
    .in_ready(fifo_ready),
    .out_data(ul_sample),
    .out_valid(ul_valid),
    .out_ready(ul_ready)
  );

  assign port.bit_clk = s_r.clk_o;
  assign port.hs_data = s_r.dat_o;
  assign dn_ready = s_r.dn_ready;
  assign test_mode = s_r.mode;
  assign xcdr_hold = s_r.hold;
  assign xcdr_restart = s_r.restart;
endmodule

/* File: hdl/stsp_pkg.sv */
// Constants and types shared by both ends of the speech test port
package stsp_pkg;
  localparam int SAMPLE_W = 13;
  localparam int CLK_HZ = 125_000_000;
  localparam int BIT_RATE_HZ = 104_000;
  localparam int SAMPLE_RATE_HZ = 8_000;
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int SETTLE_S = 1;
  localparam int SETTLE_CYC = CLK_HZ * SETTLE_S + 1;
  localparam int RESET_MS = 4;
  localparam int RESET_CYC = (CLK_HZ / 1000) * RESET_MS;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_LEN = 3;
  localparam logic [3:0] LAST_BIT = 4'h000C;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 13'h0000;
  typedef enum logic [1:0] {
    STSP_NORMAL,
    STSP_DOWNLINK,
    STSP_UPLINK,
    STSP_ACOUSTIC
  } stsp_mode_t;
  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} stsp_phase_t;
  typedef enum logic [1:0] {SIM_IDLE, SIM_SETTLE, SIM_RESET, SIM_RUN} stsp_sim_st_t;
endpackage

/* File: hdl/stsp_if.sv */
// Pin bundle between handset and test simulator
`timescale 1ns/10ps
interface stsp_if;
  logic bit_clk;
  logic hs_data;
  logic sim_data;
  logic ctl1;
  logic ctl2;
  logic test_rst_n;
  modport handset_mp (output bit_clk, output hs_data, input sim_data, input ctl1, input ctl2, input test_rst_n);
  modport sim_mp (input bit_clk, input hs_data, output sim_data, output ctl1, output ctl2, output test_rst_n);
endinterface

/* File: hdl/stsp_sim.sv */
// Test simulator end of the speech test port
`timescale 1ns/10ps
module stsp_sim
  import stsp_pkg::*;
#(
  parameter int SETTLE_CYC_P = stsp_pkg::SETTLE_CYC,
  parameter int RESET_CYC_P = stsp_pkg::RESET_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  stsp_if.sim_mp port, // Test port pins
  input wire logic start, // Begin a test sequence
  input wire stsp_pkg::stsp_mode_t req_mode, // Mode for the control lines
  output logic busy, // Settle or reset in progress
  input wire logic [stsp_pkg::SAMPLE_W-1:0] ul_sample, // Sample to feed the encoder
  input wire logic ul_valid, // Sample present
  output logic ul_ready, // Sample taken
  output logic [stsp_pkg::SAMPLE_W-1:0] dn_sample, // Sample from the decoder
  output logic dn_valid // Decoder sample pulse
);
  import stsp_pkg::*;

  typedef struct packed {
    stsp_sim_st_t st;
    logic [26:0] cnt;
    logic [SYNC_LEN-1:0] ks;
    logic k_f;
    logic [SYNC_LEN-1:0] ds;
    logic d_f;
    logic c1;
    logic c2;
    logic rst_o;
    logic dat_o;
    logic [3:0] bitn;
    logic [SAMPLE_W-1:0] txw;
    logic [SAMPLE_W-1:0] rxw;
    logic ul_ready;
    logic dn_valid;
    logic [SAMPLE_W-1:0] dn_sample;
    logic busy;
  } stsp_sim_t;

  localparam logic [26:0] SETTLE_LAST = 27'(SETTLE_CYC_P - 1);
  localparam logic [26:0] RESET_LAST = 27'(RESET_CYC_P - 1);

  stsp_sim_t s_r, s_nxt;
  logic [SAMPLE_W-1:0] w;

  always_comb begin
    s_nxt = s_r;
    w = ul_valid ? ul_sample : SAMPLE_RST;
    s_nxt.ks = {s_r.ks[SYNC_LEN-2:0], port.bit_clk};
    s_nxt.k_f = (s_r.ks[1] == s_r.ks[2]) ? s_r.ks[2] : s_r.k_f;
    s_nxt.ds = {s_r.ds[SYNC_LEN-2:0], port.hs_data};
    s_nxt.d_f = (s_r.ds[1] == s_r.ds[2]) ? s_r.ds[2] : s_r.d_f;
    s_nxt.ul_ready = 1'b0;
    s_nxt.dn_valid = 1'b0;
    s_nxt.cnt = s_r.cnt + 27'h0000_001;
    if (start) begin
      {s_nxt.c1, s_nxt.c2} = req_mode;
      s_nxt.cnt = '0;
      s_nxt.busy = 1'b1;
      s_nxt.st = SIM_SETTLE;
    end else begin
      case (s_r.st)
        SIM_IDLE: begin
          s_nxt.busy = 1'b0;
        end
        SIM_SETTLE: begin
          if (s_r.cnt == SETTLE_LAST) begin
            s_nxt.cnt = '0;
            s_nxt.rst_o = 1'b0;
            s_nxt.st = SIM_RESET;
          end
        end
        SIM_RESET: begin
          s_nxt.bitn = 4'h0000;
          if (s_r.cnt == RESET_LAST) begin
            s_nxt.rst_o = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.st = SIM_RUN;
          end
        end
        SIM_RUN: begin
          // change on falling edge, MSB first
          if (s_r.k_f && !s_nxt.k_f) begin
            if (s_r.bitn == 4'h0000) begin
              s_nxt.ul_ready = ul_valid;
              s_nxt.dat_o = w[SAMPLE_W-1];
              s_nxt.txw = {w[SAMPLE_W-2:0], 1'b0};
            end else begin
              s_nxt.dat_o = s_r.txw[SAMPLE_W-1];
              s_nxt.txw = {s_r.txw[SAMPLE_W-2:0], 1'b0};
            end
          end
          // capture on rising edge; wrap at 13
          if (!s_r.k_f && s_nxt.k_f) begin
            s_nxt.rxw = {s_r.rxw[SAMPLE_W-2:0], s_r.d_f};
            if (s_r.bitn == LAST_BIT) begin
              s_nxt.bitn = 4'h0000;
              s_nxt.dn_valid = 1'b1;
              s_nxt.dn_sample = {s_r.rxw[SAMPLE_W-2:0], s_r.d_f};
            end else begin
              s_nxt.bitn = s_r.bitn + 4'h0001;
            end
          end
        end
        default: begin
          s_nxt.st = SIM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.ks <= '1;
      s_r.k_f <= 1'b1;
      s_r.rst_o <= 1'b1;
      s_r.dat_o <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.sim_data = s_r.dat_o;
  assign port.ctl1 = s_r.c1;
  assign port.ctl2 = s_r.c2;
  assign port.test_rst_n = s_r.rst_o;
  assign busy = s_r.busy;
  assign ul_ready = s_r.ul_ready;
  assign dn_sample = s_r.dn_sample;
  assign dn_valid = s_r.dn_valid;
endmodule

/* File: verif/stsp_sva.sv */
// Link timing checks for the speech test port
`timescale 1ns/10ps
module stsp_sva
  import stsp_pkg::*;
#(
  parameter int RESET_CYC_P = 1000
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic bit_clk, // Link clock
  input wire logic hs_data, // Handset data
  input wire logic sim_data, // Simulator data
  input wire logic ctl1, // Control 1
  input wire logic ctl2, // Control 2
  input wire logic test_rst_n // Test reset
);
  int lo_c;
  int hi_c;
  int rise_c;
  int rst_c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) begin
    lo_c <= (!reset_n || bit_clk) ? 0 : lo_c + 1;
    hi_c <= (!reset_n || !bit_clk) ? 0 : hi_c + 1;
    rst_c <= (!reset_n || test_rst_n) ? 0 : rst_c + 1;
    if (!reset_n || !test_rst_n || hi_c > 601) begin
      rise_c <= 0;
    end else if ($rose(bit_clk)) begin
      rise_c <= rise_c + 1;
    end
  end
  a_clk_rst_high: assert property (!test_rst_n [*8] |-> bit_clk)
    else $error("bit clock low in test reset");
  a_low_half: assert property ($rose(bit_clk) && test_rst_n |-> lo_c == HALF_BIT_CYC)
    else $error("low half period wrong");
  a_high_half: assert property ($fell(bit_clk) && rise_c != 0 |-> hi_c == HALF_BIT_CYC)
    else $error("high half period wrong");
  a_burst_len: assert property (hi_c == 601 && rise_c != 0 && test_rst_n |-> rise_c == SAMPLE_W)
    else $error("burst not 13 bits");
  a_hs_stable: assert property (!bit_clk && !$fell(bit_clk) |-> $stable(hs_data))
    else $error("handset data moved while clock low");
  a_sim_stable: assert property ($rose(bit_clk) |-> $past(sim_data, 8) == sim_data)
    else $error("simulator data moved near rise");
  a_normal_quiet: assert property ({ctl1, ctl2} == 2'h0 && $past({ctl1, ctl2}, 8) == 2'h0 && bit_clk |=> bit_clk)
    else $error("burst in normal mode");
  a_settle_first: assert property ($changed({ctl1, ctl2}) |-> test_rst_n [*8])
    else $error("reset too soon after control change");
  a_reset_len: assert property ($rose(test_rst_n) |-> rst_c >= RESET_CYC_P)
    else $error("test reset pulse short");
  c_release: cover property ($rose(test_rst_n));
  c_full_burst: cover property (hi_c == 601 && rise_c == SAMPLE_W);
  c_abort: cover property (!test_rst_n && rise_c == 0 && $rose(bit_clk));
endmodule

/* File: verif/stsp_tb_top.sv */
// Bench joining handset and simulator ends
`timescale 1ns/10ps
module stsp_tb_top;
  import stsp_pkg::*;
  typedef struct packed {
    stsp_mode_t req;
    logic sel;
    stsp_mode_t cmd;
    stsp_mode_t exp;
    logic rst;
    logic brs;
  } stsp_row_t;
  localparam int SET_P = 200;
  localparam int RST_P = 1000;
  logic clk, reset_n, sel_by_command, start, en, bc_q, hs, rs, fl;
  logic h_dn_valid = 1'b0, h_ul_ready = 1'b0, s_ul_valid = 1'b0;
  logic dn_ready, h_ul_valid, xcdr_hold, xcdr_restart, busy, s_ul_ready, s_dn_valid;
  stsp_mode_t cmd_mode, req_mode, test_mode;
  logic [SAMPLE_W-1:0] h_ul_sample, s_dn_sample, w_sh;
  logic [SAMPLE_W-1:0] h_dn_sample = '0, s_ul_sample = '0;
  logic [SAMPLE_W-1:0] wq[$], dnq[$], ulq[$];
  logic [SAMPLE_W-1:0] dv[2] = '{13'h1_0A5, 13'h0_F5A};
  logic [SAMPLE_W-1:0] uv[2] = '{13'h1_FFE, 13'h0_001};
  int n_fail, total_checks, w_n, di, ui, wb, db, ub;
  stsp_row_t rows[6];
  stsp_if pif();
  stsp_handset stsp_handset_i (.clk(clk), .reset_n(reset_n), .port(pif.handset_mp), .sel_by_command(sel_by_command),
    .cmd_mode(cmd_mode), .dn_sample(h_dn_sample), .dn_valid(h_dn_valid), .dn_ready(dn_ready), .ul_sample(h_ul_sample),
    .ul_valid(h_ul_valid), .ul_ready(h_ul_ready), .test_mode(test_mode), .xcdr_hold(xcdr_hold),
    .xcdr_restart(xcdr_restart));
  stsp_sim #(.SETTLE_CYC_P(SET_P), .RESET_CYC_P(RST_P)) stsp_sim_i (.clk(clk), .reset_n(reset_n),
    .port(pif.sim_mp), .start(start), .req_mode(req_mode), .busy(busy), .ul_sample(s_ul_sample),
    .ul_valid(s_ul_valid), .ul_ready(s_ul_ready), .dn_sample(s_dn_sample), .dn_valid(s_dn_valid));
  stsp_sva #(.RESET_CYC_P(RST_P)) stsp_sva_i (.clk(clk), .reset_n(reset_n), .bit_clk(pif.bit_clk),
    .hs_data(pif.hs_data), .sim_data(pif.sim_data), .ctl1(pif.ctl1), .ctl2(pif.ctl2), .test_rst_n(pif.test_rst_n));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    $display("ERROR at %0t: wait ran out", $time);
    results();
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Wire words rebuilt from handset data, sampled at bit clock rise
  always @(posedge clk) begin
    bc_q <= pif.bit_clk;
    if (pif.test_rst_n !== 1'b1) begin
      w_n = 0;
    end else if (pif.bit_clk === 1'b1 && bc_q === 1'b0) begin
      w_sh = {w_sh[SAMPLE_W-2:0], pif.hs_data};
      w_n = (w_n == SAMPLE_W - 1) ? 0 : w_n + 1;
      if (w_n == 0) wq.push_back(w_sh);
    end
    if (s_dn_valid === 1'b1) dnq.push_back(s_dn_sample);
    if (h_ul_valid === 1'b1 && h_ul_ready === 1'b1) ulq.push_back(h_ul_sample);
    if (dn_ready === 1'b1) di <= di + 1;
    if (s_ul_ready === 1'b1) ui <= ui + 1;
  end
  // Sample sources; uplink consumer stalls every other cycle
  always @(negedge clk) begin
    h_ul_ready <= ~h_ul_ready;
    h_dn_sample <= dv[di % 2];
    h_dn_valid <= en && di < 2;
    s_ul_sample <= uv[ui % 2];
    s_ul_valid <= en && ui < 2;
  end
  initial begin
    reset_n = 0;
    sel_by_command = 0;
    cmd_mode = STSP_NORMAL;
    req_mode = STSP_NORMAL;
    start = 0;
    en = 0;
    rows[0] = '{STSP_NORMAL, 1'b0, STSP_NORMAL, STSP_NORMAL, 1'b0, 1'b0};
    rows[1] = '{STSP_DOWNLINK, 1'b0, STSP_NORMAL, STSP_DOWNLINK, 1'b1, 1'b0};
    rows[2] = '{STSP_UPLINK, 1'b0, STSP_NORMAL, STSP_UPLINK, 1'b1, 1'b1};
    rows[3] = '{STSP_UPLINK, 1'b1, STSP_NORMAL, STSP_NORMAL, 1'b0, 1'b0};
    rows[4] = '{STSP_NORMAL, 1'b1, STSP_DOWNLINK, STSP_DOWNLINK, 1'b1, 1'b0};
    rows[5] = '{STSP_ACOUSTIC, 1'b0, STSP_NORMAL, STSP_ACOUSTIC, 1'b1, 1'b1};
    repeat (6) @(negedge clk);
    reset_n = 1;
    chk(pif.bit_clk, 1);
    chk(xcdr_hold, 1);
    $display("test reset done");
    foreach (rows[r]) begin
      sel_by_command = rows[r].sel;
      cmd_mode = rows[r].cmd;
      req_mode = rows[r].req;
      start = 1;
      @(negedge clk);
      start = 0;
      hs = 0;
      rs = 0;
      fl = 0;
      for (int i = 0; i < 3000 && (i < 2 || busy === 1'b1); i++) begin
        @(negedge clk);
        hs |= xcdr_hold;
      end
      if (busy !== 1'b0) tmo();
      for (int i = 0; i < 30; i++) begin
        @(negedge clk);
        rs |= xcdr_restart;
        fl |= !pif.bit_clk;
      end
      chk(test_mode, rows[r].exp);
      chk(hs, 1);
      chk(rs, rows[r].rst);
      chk(fl, rows[r].brs);
      $display("test row %0d done", r);
    end
    repeat (2000) @(negedge clk);
    wb = wq.size();
    db = dnq.size();
    ub = ulq.size();
    en = 1;
    for (int i = 0; i < 50000 && (wq.size() < wb + 3 || dnq.size() < db + 3 || ulq.size() < ub + 3); i++) begin
      @(negedge clk);
    end
    if (wq.size() < wb + 3 || dnq.size() < db + 3 || ulq.size() < ub + 3) tmo();
    for (int i = 0; i < 3; i++) begin
      chk(wq[wb+i], (i != 0) ? dv[i-1] : 13'h1_FFF);
      chk(dnq[db+i], (i != 0) ? dv[i-1] : 13'h1_FFF);
      chk(ulq[ub+i], (i != 0) ? uv[i-1] : 13'h0_000);
    end
    // Uplink FIFO drained after the last word
    chk(h_ul_valid, 0);
    $display("test stream done");
    // Both ends reset in mid-run
    reset_n = 0;
    repeat (4) @(negedge clk);
    chk(pif.bit_clk, 1);
    chk(pif.hs_data, 1);
    chk(xcdr_hold, 1);
    chk(test_mode, STSP_NORMAL);
    chk(h_ul_valid, 0);
    reset_n = 1;
    repeat (2) @(negedge clk);
    chk(xcdr_restart, 0);
    chk(pif.bit_clk, 1);
    $display("test mid reset done");
    results();
  end
endmodule
